// ===== include/ptc_params.svh
// Purpose: Address map, bit positions and reset values of the timer control block
// Assumes: 16-bit register addresses, 4-bit register data
// Notes: Definitions only
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

`define PTC_ADDR_MODE 16'hffc0
`define PTC_ADDR_OUTCTL 16'hffc1
`define PTC_ADDR_RUN0 16'hffc2
`define PTC_ADDR_RUN1 16'hffc3
`define PTC_ADDR_RLD0L 16'hffc4
`define PTC_ADDR_RLD0H 16'hffc5
`define PTC_ADDR_RLD1L 16'hffc6
`define PTC_ADDR_RLD1H 16'hffc7
`define PTC_ADDR_CNT0L 16'hffc8
`define PTC_ADDR_CNT0H 16'hffc9
`define PTC_ADDR_CNT1L 16'hffca
`define PTC_ADDR_CNT1H 16'hffcb
`define PTC_ADDR_MASK 16'hffe2
`define PTC_ADDR_FLAG 16'hfff2

`define PTC_BIT_RUN 0
`define PTC_BIT_PRESET 1
`define PTC_BIT_OUTEN 2
`define PTC_BIT_OUT_CHANNEL_SELECT 3
`define PTC_BIT_WIDE 3
`define PTC_BIT_T0 0
`define PTC_BIT_T1 1

`define PTC_RST_NIB 4'h0
`define PTC_RST_CNT 8'h00
`define PTC_CNT_ZERO 8'h00
`define PTC_CNT_ONE 8'h01
`define PTC_RST_BITS 2'h0

`endif

// ===== include/ptc_pkg.sv
// Purpose: Types shared by the timer control block and its bench
// Assumes: Two 8-bit timers, 4-bit register data
// Notes: Constants live in ptc_params.svh
package ptc_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [3:0] wdata;
  } ptc_bus_req_t;

  typedef struct packed {
    logic [1:0] run_req;
    logic [1:0] run_act;
    logic [1:0] reload_pend;
    logic [1:0] irq_flag;
    logic [1:0] irq_mask;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] reload;
    logic [1:0][3:0] hi_latch;
    logic out_en;
    logic out_sel;
    logic wide;
    logic timer_output_signal;
    logic clk_prev;
    logic [3:0] rdata;
  } ptc_state_t;

endpackage

// ===== design/ptc_timer.sv
// Purpose: Control, output and interrupt logic of a dual 8-bit reloadable down-counter timer
// Assumes: TMR_CLK_IN is the prescaled timer clock, synchronous to SYS_CLK and slower than it
// Notes: Register data read back one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "ptc_params.svh"

module ptc_timer
  import ptc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire ptc_bus_req_t REG_REQ,
  output logic [3:0] REG_RDATA,
  input wire logic TMR_CLK_IN,
  output logic TIMER_OUT_PIN,
  output logic IRQ_T0,
  output logic IRQ_T1,
  output logic UNDERFLOW_T1
);

  ptc_state_t s_reg;
  ptc_state_t s_next;
  logic fall;
  logic rise;
  logic [1:0] step;
  logic [1:0] uf;
  logic [1:0] flag_set;
  logic [1:0] preset;
  logic timer_output_signal_src;

  function automatic logic wr_at(input ptc_bus_req_t r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_at(input ptc_bus_req_t r, input logic [15:0] a);
    return r.rd && (r.addr == a);
  endfunction

  always_comb begin
    s_next = s_reg;
    // Input clock edges seen against the previous sample
    fall = s_reg.clk_prev & ~TMR_CLK_IN;
    rise = ~s_reg.clk_prev & TMR_CLK_IN;
    s_next.clk_prev = TMR_CLK_IN;

    // Decrement only with the run state in force before this edge,
    // so a stop still costs one more count
    step[0] = fall & s_reg.run_act[0];
    uf[0] = step[0] && (s_reg.cnt[0] == `PTC_CNT_ZERO);
    if (s_reg.wide) begin
      step[1] = uf[0];
    end else begin
      step[1] = fall & s_reg.run_act[1];
    end
    uf[1] = step[1] && (s_reg.cnt[1] == `PTC_CNT_ZERO);

    // Chained mode reports only the upper timer
    flag_set[0] = uf[0] & ~s_reg.wide;
    flag_set[1] = uf[1];

    if (fall) begin
      s_next.run_act = s_reg.run_req;
    end

    preset[0] = wr_at(REG_REQ, `PTC_ADDR_RUN0) && REG_REQ.wdata[`PTC_BIT_PRESET];
    preset[1] = wr_at(REG_REQ, `PTC_ADDR_RUN1) && REG_REQ.wdata[`PTC_BIT_PRESET];

    for (int i = 0; i < 2; i++) begin
      if (step[i]) begin
        s_next.cnt[i] = s_reg.cnt[i] - `PTC_CNT_ONE;
      end
      if (uf[i]) begin
        s_next.reload_pend[i] = 1'b1;
      end
      if (rise && s_reg.reload_pend[i]) begin
        s_next.cnt[i] = s_reg.reload[i];
        s_next.reload_pend[i] = 1'b0;
      end
      // Preset wins over any count in the same cycle; run state is untouched
      if (preset[i]) begin
        s_next.cnt[i] = s_reg.reload[i];
        s_next.reload_pend[i] = 1'b0;
      end
    end

    // Toggle output on each underflow of the chosen channel, which chained mode forces to the upper timer
    timer_output_signal_src = (s_reg.wide | s_reg.out_sel) ? uf[1] : uf[0];
    if (timer_output_signal_src) begin
      s_next.timer_output_signal = ~s_reg.timer_output_signal;
    end

    if (wr_at(REG_REQ, `PTC_ADDR_MODE)) begin
      s_next.wide = REG_REQ.wdata[`PTC_BIT_WIDE];
    end
    if (wr_at(REG_REQ, `PTC_ADDR_OUTCTL)) begin
      s_next.out_sel = REG_REQ.wdata[`PTC_BIT_OUT_CHANNEL_SELECT];
      s_next.out_en = REG_REQ.wdata[`PTC_BIT_OUTEN];
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RUN0)) begin
      s_next.run_req[0] = REG_REQ.wdata[`PTC_BIT_RUN];
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RUN1)) begin
      s_next.run_req[1] = REG_REQ.wdata[`PTC_BIT_RUN];
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RLD0L)) begin
      s_next.reload[0][3:0] = REG_REQ.wdata;
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RLD0H)) begin
      s_next.reload[0][7:4] = REG_REQ.wdata;
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RLD1L)) begin
      s_next.reload[1][3:0] = REG_REQ.wdata;
    end
    if (wr_at(REG_REQ, `PTC_ADDR_RLD1H)) begin
      s_next.reload[1][7:4] = REG_REQ.wdata;
    end
    if (wr_at(REG_REQ, `PTC_ADDR_MASK)) begin
      s_next.irq_mask = REG_REQ.wdata[`PTC_BIT_T1:`PTC_BIT_T0];
    end

    // Set wins over a clear in the same cycle
    if (wr_at(REG_REQ, `PTC_ADDR_FLAG)) begin
      s_next.irq_flag = (s_reg.irq_flag & ~REG_REQ.wdata[`PTC_BIT_T1:`PTC_BIT_T0]) | flag_set;
    end else begin
      s_next.irq_flag = s_reg.irq_flag | flag_set;
    end

    // Read port; unmapped addresses read zero
    s_next.rdata = `PTC_RST_NIB;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        `PTC_ADDR_MODE: s_next.rdata[`PTC_BIT_WIDE] = s_reg.wide;
        `PTC_ADDR_OUTCTL: begin
          s_next.rdata[`PTC_BIT_OUT_CHANNEL_SELECT] = s_reg.out_sel;
          s_next.rdata[`PTC_BIT_OUTEN] = s_reg.out_en;
        end
        // Stop pending still reads one; preset bit always zero
        `PTC_ADDR_RUN0: s_next.rdata[`PTC_BIT_RUN] = s_reg.run_req[0] | s_reg.run_act[0];
        `PTC_ADDR_RUN1: s_next.rdata[`PTC_BIT_RUN] = s_reg.run_req[1] | s_reg.run_act[1];
        `PTC_ADDR_RLD0L: s_next.rdata = s_reg.reload[0][3:0];
        `PTC_ADDR_RLD0H: s_next.rdata = s_reg.reload[0][7:4];
        `PTC_ADDR_RLD1L: s_next.rdata = s_reg.reload[1][3:0];
        `PTC_ADDR_RLD1H: s_next.rdata = s_reg.reload[1][7:4];
        `PTC_ADDR_CNT0L: begin
          s_next.rdata = s_reg.cnt[0][3:0];
          s_next.hi_latch[0] = s_reg.cnt[0][7:4];
        end
        `PTC_ADDR_CNT0H: s_next.rdata = s_reg.hi_latch[0];
        `PTC_ADDR_CNT1L: begin
          s_next.rdata = s_reg.cnt[1][3:0];
          s_next.hi_latch[1] = s_reg.cnt[1][7:4];
        end
        `PTC_ADDR_CNT1H: s_next.rdata = s_reg.hi_latch[1];
        `PTC_ADDR_MASK: s_next.rdata[`PTC_BIT_T1:`PTC_BIT_T0] = s_reg.irq_mask;
        `PTC_ADDR_FLAG: s_next.rdata[`PTC_BIT_T1:`PTC_BIT_T0] = s_reg.irq_flag;
        default: s_next.rdata = `PTC_RST_NIB;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA = s_reg.rdata;
  // Gated after the flop on purpose; an enable change may chop half a toggle period
  assign TIMER_OUT_PIN = s_reg.out_en ? s_reg.timer_output_signal : 1'b1;
  assign IRQ_T0 = s_reg.irq_flag[0] & s_reg.irq_mask[0];
  assign IRQ_T1 = s_reg.irq_flag[1] & s_reg.irq_mask[1];
  assign UNDERFLOW_T1 = uf[1];

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence preset0_seq;
    wr_at(REG_REQ, `PTC_ADDR_RUN0) && REG_REQ.wdata[`PTC_BIT_PRESET];
  endsequence

  sequence stop0_seq;
    wr_at(REG_REQ, `PTC_ADDR_RUN0) && !REG_REQ.wdata[`PTC_BIT_RUN] && s_reg.run_act[0] && !fall;
  endsequence

  sequence quiet_bus_seq;
    !REG_REQ.wr && !REG_REQ.rd;
  endsequence

  preset_load_a: assert property (preset0_seq |=> s_reg.cnt[0] == $past(s_reg.reload[0]))
    else $error("preset did not load reload value");

  preset_read_a: assert property (rd_at(REG_REQ, `PTC_ADDR_RUN0) |=> REG_RDATA[`PTC_BIT_PRESET] == 1'b0)
    else $error("preset bit read nonzero");

  stop_pending_a: assert property (stop0_seq ##1 rd_at(REG_REQ, `PTC_ADDR_RUN0) |=> REG_RDATA[`PTC_BIT_RUN])
    else $error("run bit dropped before stop");

  run_edge_a: assert property (!fall |=> s_reg.run_act == $past(s_reg.run_act))
    else $error("run state changed without falling edge");

  hold_stopped_a: assert property (!s_reg.run_act[0] && !(preset[0]) && !(rise && s_reg.reload_pend[0])
    |=> s_reg.cnt[0] == $past(s_reg.cnt[0]))
    else $error("stopped counter moved");

  flag_set_a: assert property (uf[0] && !s_reg.wide |=> s_reg.irq_flag[0])
    else $error("underflow did not set flag");

  flag_clear_a: assert property (wr_at(REG_REQ, `PTC_ADDR_FLAG) && REG_REQ.wdata[`PTC_BIT_T1] && !flag_set[1]
    |=> !s_reg.irq_flag[1])
    else $error("flag not cleared by write one");

  mask_write_a: assert property (wr_at(REG_REQ, `PTC_ADDR_MASK)
    |=> s_reg.irq_mask == $past(REG_REQ.wdata[`PTC_BIT_T1:`PTC_BIT_T0]))
    else $error("mask not stored");

  pin_idle_a: assert property (wr_at(REG_REQ, `PTC_ADDR_OUTCTL) && !REG_REQ.wdata[`PTC_BIT_OUTEN]
    ##1 quiet_bus_seq |-> TIMER_OUT_PIN)
    else $error("pin not high while disabled");

  reload_rise_a: assert property (rise && s_reg.reload_pend[1] && !preset[1]
    |=> s_reg.cnt[1] == $past(s_reg.reload[1]) && !s_reg.reload_pend[1])
    else $error("reload not settled at rising edge");

  wide_timer_output_signal_a: assert property (s_reg.wide && uf[1] |=> s_reg.timer_output_signal != $past(s_reg.timer_output_signal))
    else $error("chained output not from upper timer");

  hi_latch_a: assert property (rd_at(REG_REQ, `PTC_ADDR_CNT0L) ##1 rd_at(REG_REQ, `PTC_ADDR_CNT0H)
    |=> REG_RDATA == $past(s_reg.cnt[0][7:4], 2))
    else $error("high nibble not latched");

  hi_latch1_a: assert property (rd_at(REG_REQ, `PTC_ADDR_CNT1L) ##1 rd_at(REG_REQ, `PTC_ADDR_CNT1H)
    |=> REG_RDATA == $past(s_reg.cnt[1][7:4], 2))
    else $error("timer1 high nibble not latched");

  // Second timer and further run, count, reload, flag, output, pin and register paths of both timers
  preset_load1_a: assert property (preset[1] |=> s_reg.cnt[1] == $past(s_reg.reload[1]))
    else $error("timer1 preset did not load");

  preset_run_a: assert property (preset[0] && !fall |=> s_reg.run_act == $past(s_reg.run_act))
    else $error("preset changed run state");

  preset_pend_a: assert property (preset[0] |=> !s_reg.reload_pend[0])
    else $error("preset left reload pending");

  preset1_read_a: assert property (rd_at(REG_REQ, `PTC_ADDR_RUN1) |=> REG_RDATA[`PTC_BIT_PRESET] == 1'b0)
    else $error("timer1 preset bit read nonzero");

  run_write0_a: assert property (wr_at(REG_REQ, `PTC_ADDR_RUN0)
    |=> s_reg.run_req[0] == $past(REG_REQ.wdata[`PTC_BIT_RUN]))
    else $error("timer0 run request not stored");

  run_write1_a: assert property (wr_at(REG_REQ, `PTC_ADDR_RUN1)
    |=> s_reg.run_req[1] == $past(REG_REQ.wdata[`PTC_BIT_RUN]))
    else $error("timer1 run request not stored");

  run_take_a: assert property (fall |=> s_reg.run_act == $past(s_reg.run_req))
    else $error("run request not taken at falling edge");

  run_read_a: assert property (rd_at(REG_REQ, `PTC_ADDR_RUN0) && s_reg.run_act[0]
    |=> REG_RDATA[`PTC_BIT_RUN])
    else $error("active timer read as stopped");

  count_step0_a: assert property (step[0] && !preset[0]
    |=> s_reg.cnt[0] == $past(s_reg.cnt[0]) - `PTC_CNT_ONE)
    else $error("timer0 did not decrement");

  count_step1_a: assert property (step[1] && !preset[1]
    |=> s_reg.cnt[1] == $past(s_reg.cnt[1]) - `PTC_CNT_ONE)
    else $error("timer1 did not decrement");

  uf_pend_a: assert property (uf[0] && !preset[0] |=> s_reg.reload_pend[0])
    else $error("underflow left no reload pending");

  reload_rise0_a: assert property (rise && s_reg.reload_pend[0] && !preset[0]
    |=> s_reg.cnt[0] == $past(s_reg.reload[0]))
    else $error("timer0 reload not settled");

  flag_set1_a: assert property (uf[1] |=> s_reg.irq_flag[1])
    else $error("timer1 underflow did not set flag");

  flag_hold_a: assert property (wr_at(REG_REQ, `PTC_ADDR_FLAG) && !REG_REQ.wdata[`PTC_BIT_T0]
    && s_reg.irq_flag[0] |=> s_reg.irq_flag[0])
    else $error("zero write cleared flag");

  flag_read_a: assert property (rd_at(REG_REQ, `PTC_ADDR_FLAG)
    |=> REG_RDATA[`PTC_BIT_T1:`PTC_BIT_T0] == $past(s_reg.irq_flag))
    else $error("flag read mismatch");

  mask_read_a: assert property (rd_at(REG_REQ, `PTC_ADDR_MASK)
    |=> REG_RDATA[`PTC_BIT_T1:`PTC_BIT_T0] == $past(s_reg.irq_mask))
    else $error("mask read mismatch");

  wide_flag0_a: assert property (s_reg.wide && uf[0] && !s_reg.irq_flag[0] |=> !s_reg.irq_flag[0])
    else $error("chained mode set lower flag");

  wide_hold_a: assert property (s_reg.wide && !uf[0] && !preset[1] && !(rise && s_reg.reload_pend[1])
    |=> s_reg.cnt[1] == $past(s_reg.cnt[1]))
    else $error("upper timer moved without carry");

  sel0_timer_output_signal_a: assert property (!s_reg.wide && !s_reg.out_sel && uf[0] |=> s_reg.timer_output_signal != $past(s_reg.timer_output_signal))
    else $error("timer0 channel did not toggle output");

  sel1_timer_output_signal_a: assert property (!s_reg.wide && s_reg.out_sel && uf[1] |=> s_reg.timer_output_signal != $past(s_reg.timer_output_signal))
    else $error("timer1 channel did not toggle output");

  timer_output_signal_hold_a: assert property (!uf[0] && !uf[1] |=> s_reg.timer_output_signal == $past(s_reg.timer_output_signal))
    else $error("output toggled without underflow");

  outctl_write_a: assert property (wr_at(REG_REQ, `PTC_ADDR_OUTCTL)
    |=> s_reg.out_en == $past(REG_REQ.wdata[`PTC_BIT_OUTEN])
    && s_reg.out_sel == $past(REG_REQ.wdata[`PTC_BIT_OUT_CHANNEL_SELECT]))
    else $error("output control not stored");

  pin_follow_a: assert property (s_reg.out_en |-> TIMER_OUT_PIN == s_reg.timer_output_signal)
    else $error("enabled pin not following output");

  pin_high_a: assert property (!s_reg.out_en |-> TIMER_OUT_PIN)
    else $error("disabled pin not high");

  // Read data stands one cycle only, so a stale nibble cannot be mistaken for an answer
  rdata_idle_a: assert property (!REG_REQ.rd |=> REG_RDATA == `PTC_RST_NIB)
    else $error("read data without read strobe");

endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the dual timer control block
// Assumes: Bench drives the timer clock slowly, several system cycles per phase
// Notes: One toggle flop feeds the pin, so pin checks follow the whole run
`timescale 1ns/1ps
`default_nettype none
`include "ptc_params.svh"

module tb import ptc_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  ptc_bus_req_t req = '0;
  logic tclk = 1'b0;
  logic [3:0] rdata;
  logic pin;
  logic irq0;
  logic irq1;
  logic uf1;
  int err_count = 0;
  int total_checks = 0;
  int uf_seen = 0;

  always #4 sys_clk = ~sys_clk;

  ptc_timer DUT (.SYS_CLK(sys_clk), .RESET(reset), .REG_REQ(req), .REG_RDATA(rdata), .TMR_CLK_IN(tclk),
    .TIMER_OUT_PIN(pin), .IRQ_T0(irq0), .IRQ_T1(irq1), .UNDERFLOW_T1(uf1));

  always @(posedge sys_clk) begin
    if (uf1 === 1'b1)
      uf_seen++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [3:0] exp);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
    @(posedge sys_clk);
    req <= '0;
    #1;
    chk({4'h0, rdata}, {4'h0, exp});
  endtask

  // Each pass gives one rising and one falling timer edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tclk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      tclk <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask

  task automatic t_reset;
    rchk(`PTC_ADDR_OUTCTL, 4'h0);
    rchk(`PTC_ADDR_RUN0, 4'h0);
    rchk(`PTC_ADDR_MASK, 4'h0);
    rchk(`PTC_ADDR_FLAG, 4'h0);
    rchk(16'hffd0, 4'h0);
    chk({7'h00, pin}, 8'h01);
  endtask

  task automatic t_preset;
    wr(`PTC_ADDR_RLD0L, 4'h3);
    wr(`PTC_ADDR_RUN0, 4'h2);
    rchk(`PTC_ADDR_CNT0L, 4'h3);
    rchk(`PTC_ADDR_CNT0H, 4'h0);
    rchk(`PTC_ADDR_RUN0, 4'h0);
    tick(2);
    rchk(`PTC_ADDR_CNT0L, 4'h3);
    wr(`PTC_ADDR_RLD0L, 4'h5);
    wr(`PTC_ADDR_RUN0, 4'h0);
    rchk(`PTC_ADDR_CNT0L, 4'h3);
  endtask

  task automatic t_run_stop;
    wr(`PTC_ADDR_RUN0, 4'h1);
    rchk(`PTC_ADDR_RUN0, 4'h1);
    tick(1);
    rchk(`PTC_ADDR_CNT0L, 4'h3);
    tick(1);
    rchk(`PTC_ADDR_CNT0L, 4'h2);
    wr(`PTC_ADDR_RUN0, 4'h0);
    rchk(`PTC_ADDR_RUN0, 4'h1);
    tick(1);
    rchk(`PTC_ADDR_CNT0L, 4'h1);
    rchk(`PTC_ADDR_RUN0, 4'h0);
    tick(2);
    rchk(`PTC_ADDR_CNT0L, 4'h1);
  endtask

  task automatic t_underflow;
    wr(`PTC_ADDR_OUTCTL, 4'h4);
    chk({7'h00, pin}, 8'h00);
    wr(`PTC_ADDR_RUN0, 4'h1);
    tick(2);
    rchk(`PTC_ADDR_FLAG, 4'h0);
    tick(1);
    rchk(`PTC_ADDR_FLAG, 4'h1);
    chk({7'h00, irq0}, 8'h00);
    chk({7'h00, pin}, 8'h01);
    wr(`PTC_ADDR_MASK, 4'h1);
    chk({7'h00, irq0}, 8'h01);
    tick(1);
    rchk(`PTC_ADDR_CNT0L, 4'h4);
    wr(`PTC_ADDR_FLAG, 4'h0);
    rchk(`PTC_ADDR_FLAG, 4'h1);
    wr(`PTC_ADDR_FLAG, 4'h1);
    rchk(`PTC_ADDR_FLAG, 4'h0);
    chk({7'h00, irq0}, 8'h00);
    wr(`PTC_ADDR_RUN0, 4'h3);
    tick(1);
    rchk(`PTC_ADDR_CNT0L, 4'h4);
    wr(`PTC_ADDR_RUN0, 4'h0);
    tick(1);
  endtask

  task automatic t_channel;
    wr(`PTC_ADDR_OUTCTL, 4'hc);
    wr(`PTC_ADDR_RUN1, 4'h2);
    wr(`PTC_ADDR_RUN1, 4'h1);
    tick(2);
    rchk(`PTC_ADDR_FLAG, 4'h2);
    chk({7'h00, pin}, 8'h00);
    chk(uf_seen[7:0], 8'h01);
    wr(`PTC_ADDR_MASK, 4'h2);
    chk({6'h00, irq1, irq0}, 8'h02);
    wr(`PTC_ADDR_RUN1, 4'h0);
    tick(1);
    chk({7'h00, pin}, 8'h01);
    wr(`PTC_ADDR_FLAG, 4'h2);
  endtask

  task automatic t_wide;
    wr(`PTC_ADDR_MODE, 4'h8);
    wr(`PTC_ADDR_OUTCTL, 4'h4);
    wr(`PTC_ADDR_RLD0L, 4'h0);
    wr(`PTC_ADDR_RUN0, 4'h2);
    wr(`PTC_ADDR_RUN1, 4'h2);
    wr(`PTC_ADDR_RUN0, 4'h1);
    tick(2);
    rchk(`PTC_ADDR_FLAG, 4'h2);
    chk({7'h00, pin}, 8'h00);
    rchk(`PTC_ADDR_CNT0L, 4'hf);
    rchk(`PTC_ADDR_CNT0H, 4'hf);
    rchk(`PTC_ADDR_CNT1L, 4'hf);
    rchk(`PTC_ADDR_CNT1H, 4'hf);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_preset();
    t_run_stop();
    t_underflow();
    t_channel();
    t_wide();
    end_of_test();
  end
endmodule
`default_nettype wire
